// file: rtl/ffop_pkg.sv
package ffop_pkg;
	// widths of the smaller device
	localparam int DATA_W = 18;
	localparam int OFS_W = 13;
	localparam int CNT_W = 14;
	localparam int SER_PTR_W = 5;
	localparam int PAD_W = DATA_W - OFS_W;
	// occupancy thresholds in fall-through mode
	localparam logic [CNT_W-1:0] CAPACITY = 14'h2001;
	localparam logic [CNT_W-1:0] HALF_THR = 14'h1002;
	localparam logic [CNT_W-1:0] AE_MARGIN = 14'h0002;
	// serial chain length and last bit index
	localparam logic [SER_PTR_W-1:0] SER_LAST = 5'h19;
	// offset reset values per loading method
	localparam logic [OFS_W-1:0] DEF_OFS_PAR = 13'h007f;
	localparam logic [OFS_W-1:0] DEF_OFS_SER = 13'h03ff;
	// head buffer shape
	localparam int BUF_DEPTH = 8;
	localparam int BUF_AW = 3;
	// offset register pointer positions
	localparam logic PTR_EMPTY = 1'b0;
	localparam logic PTR_FULL = 1'b1;

	typedef struct packed {
		logic serial_mode;
		logic [OFS_W-1:0] empty_ofs;
		logic [OFS_W-1:0] full_ofs;
		logic [OFS_W-1:0] empty_ofs_s1;
		logic [OFS_W-1:0] full_ofs_s1;
		logic wr_ptr;
		logic rd_ptr;
		logic [SER_PTR_W-1:0] ser_ptr;
		logic [CNT_W-1:0] count;
		logic [DATA_W-1:0] dout;
		logic input_ready_n;
		logic output_ready_n;
		logic half_full_n;
		logic almost_empty_n;
		logic almost_full_n;
	} ffop_state_t;
endpackage

// file: rtl/ffop_top.sv
`timescale 1ns/1ps

// head buffer: words waiting for the output in fall-through order
module ffop_buffer #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic flush_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr_idx;
		logic [AW-1:0] rd_idx;
		logic [AW:0] used;
	} ffop_buf_t;

	ffop_buf_t b_q, b_d;
	logic push, pop;

	// handshakes on both sides
	assign in_ready_out = (b_q.used != (AW+1)'(DEPTH));
	assign out_valid_out = (b_q.used != '0);
	assign out_data_out = b_q.mem[b_q.rd_idx];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_ready_in && out_valid_out;

	// next state of the buffer
	always_comb begin
		b_d = b_q;
		if (push) begin
			b_d.mem[b_q.wr_idx] = in_data_in;
			b_d.wr_idx = b_q.wr_idx + 1'b1;
		end
		if (pop) begin
			b_d.rd_idx = b_q.rd_idx + 1'b1;
		end
		b_d.used = b_q.used + (AW+1)'(push) - (AW+1)'(pop);
		if (flush_in) begin
			b_d.wr_idx = '0;
			b_d.rd_idx = '0;
			b_d.used = '0;
		end
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			b_q <= '0;
		end else begin
			b_q <= b_d;
		end
	end
endmodule

module ffop_top (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic master_reset_n_in,
	input wire logic partial_reset_n_in,
	input wire logic wr_clk_edge_in,
	input wire logic rd_clk_edge_in,
	input wire logic offset_load_select_in,
	input wire logic write_strobe_n_in,
	input wire logic read_strobe_n_in,
	input wire logic serial_shift_enable_n_in,
	input wire logic serial_data_in,
	input wire logic [ffop_pkg::DATA_W-1:0] data_in_bus_in,
	output logic [ffop_pkg::DATA_W-1:0] data_out_bus_out,
	output logic input_ready_n_out,
	output logic output_ready_n_out,
	output logic half_full_n_out,
	output logic almost_empty_n_out,
	output logic almost_full_n_out,
	output logic serial_mode_out,
	output logic head_buffer_ready_out
);
	import ffop_pkg::*;

	ffop_state_t s_q, s_d;
	logic master_rst;
	logic partial_rst;
	logic any_rst;
	logic par_wr;
	logic par_rd;
	logic ser_shift;
	logic mem_wr;
	logic mem_rd;
	logic buf_in_ready;
	logic buf_out_valid;
	logic buf_ready_q;
	logic [DATA_W-1:0] buf_head;
	logic [CNT_W-1:0] cnt_next;
	logic [2*OFS_W-1:0] chain;
	logic [2*OFS_W-1:0] chain_next;

	// reset pins are levels, taken on every clock
	assign master_rst = !master_reset_n_in;
	assign partial_rst = !partial_reset_n_in;
	assign any_rst = master_rst || partial_rst;

	// decode of the control pin combinations
	assign par_wr = wr_clk_edge_in && !offset_load_select_in && !write_strobe_n_in
		&& read_strobe_n_in && serial_shift_enable_n_in && !s_q.serial_mode;
	assign par_rd = rd_clk_edge_in && !offset_load_select_in && write_strobe_n_in
		&& !read_strobe_n_in && serial_shift_enable_n_in;
	assign ser_shift = wr_clk_edge_in && !offset_load_select_in && write_strobe_n_in
		&& read_strobe_n_in && !serial_shift_enable_n_in && s_q.serial_mode;
	assign mem_wr = wr_clk_edge_in && offset_load_select_in && !write_strobe_n_in
		&& s_q.input_ready_n == 1'b0 && buf_in_ready;
	assign mem_rd = rd_clk_edge_in && offset_load_select_in && !read_strobe_n_in
		&& !s_q.output_ready_n;

	// occupancy moves only on memory accesses
	assign cnt_next = s_q.count + CNT_W'(mem_wr) - CNT_W'(mem_rd);

	// serial chain view: empty offset in the low half
	assign chain = {s_q.full_ofs, s_q.empty_ofs};

	// chain with the addressed bit replaced by the serial pin
	always_comb begin
		chain_next = chain;
		chain_next[s_q.ser_ptr] = serial_data_in;
	end

	// next state of the flag and offset core
	always_comb begin
		s_d = s_q;
		s_d.count = cnt_next;
		if (par_wr) begin
			if (s_q.wr_ptr == PTR_EMPTY) begin
				s_d.empty_ofs = data_in_bus_in[OFS_W-1:0];
			end else begin
				s_d.full_ofs = data_in_bus_in[OFS_W-1:0];
			end
			s_d.wr_ptr = !s_q.wr_ptr;
		end
		if (ser_shift) begin
			// one bit per write edge, pointer held while paused
			s_d.empty_ofs = chain_next[OFS_W-1:0];
			s_d.full_ofs = chain_next[2*OFS_W-1:OFS_W];
			s_d.ser_ptr = (s_q.ser_ptr == SER_LAST) ? '0
				: s_q.ser_ptr + 1'b1;
		end
		if (par_rd) begin
			// readback replaces the presented word
			s_d.dout = {{PAD_W{1'b0}},
				(s_q.rd_ptr == PTR_EMPTY) ? s_q.empty_ofs : s_q.full_ofs};
			s_d.rd_ptr = !s_q.rd_ptr;
		end else if (mem_rd) begin
			s_d.dout = buf_out_valid ? buf_head : s_q.dout;
		end
		// offsets reach the flag compare two edges later
		if (wr_clk_edge_in) begin
			s_d.full_ofs_s1 = s_q.full_ofs;
			s_d.almost_full_n = !(s_q.count >= CAPACITY - CNT_W'(s_q.full_ofs_s1));
		end
		if (rd_clk_edge_in) begin
			s_d.empty_ofs_s1 = s_q.empty_ofs;
			s_d.almost_empty_n = (s_q.count >= CNT_W'(s_q.empty_ofs_s1) + AE_MARGIN);
		end
		s_d.output_ready_n = (cnt_next == '0);
		s_d.input_ready_n = (cnt_next == CAPACITY);
		s_d.half_full_n = !(cnt_next >= HALF_THR);
		// partial reset clears data, keeps offsets and pointers
		if (any_rst) begin
			s_d.count = '0;
			s_d.dout = '0;
			s_d.output_ready_n = 1'b1;
			s_d.input_ready_n = 1'b0;
			s_d.half_full_n = 1'b1;
			s_d.almost_full_n = 1'b1;
			s_d.almost_empty_n = 1'b0;
		end
		// master reset also picks method, defaults and pointers
		if (master_rst) begin
			s_d.serial_mode = offset_load_select_in;
			s_d.empty_ofs = offset_load_select_in ? DEF_OFS_SER : DEF_OFS_PAR;
			s_d.full_ofs = offset_load_select_in ? DEF_OFS_SER : DEF_OFS_PAR;
			s_d.empty_ofs_s1 = s_d.empty_ofs;
			s_d.full_ofs_s1 = s_d.full_ofs;
			s_d.wr_ptr = PTR_EMPTY;
			s_d.rd_ptr = PTR_EMPTY;
			s_d.ser_ptr = '0;
		end
	end

	// state register, async clear to the parallel defaults
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			s_q <= '{serial_mode: 1'b0, empty_ofs: DEF_OFS_PAR, full_ofs: DEF_OFS_PAR,
				empty_ofs_s1: DEF_OFS_PAR, full_ofs_s1: DEF_OFS_PAR, wr_ptr: PTR_EMPTY,
				rd_ptr: PTR_EMPTY, ser_ptr: '0, count: '0, dout: '0,
				input_ready_n: 1'b0, output_ready_n: 1'b1, half_full_n: 1'b1,
				almost_empty_n: 1'b0, almost_full_n: 1'b1};
			buf_ready_q <= 1'b1;
		end else begin
			s_q <= s_d;
			buf_ready_q <= buf_in_ready;
		end
	end

	// head words of the data stream, stalls memory writes when full
	ffop_buffer #(
		.WIDTH(DATA_W),
		.DEPTH(BUF_DEPTH),
		.AW(BUF_AW)
	) u_buffer (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.flush_in(any_rst),
		.in_valid_in(mem_wr),
		.in_ready_out(buf_in_ready),
		.in_data_in(data_in_bus_in),
		.out_valid_out(buf_out_valid),
		.out_ready_in(mem_rd && !par_rd),
		.out_data_out(buf_head)
	);

	// outputs straight from flops; no serial readout port exists
	assign data_out_bus_out = s_q.dout;
	assign input_ready_n_out = s_q.input_ready_n;
	assign output_ready_n_out = s_q.output_ready_n;
	assign half_full_n_out = s_q.half_full_n;
	assign almost_empty_n_out = s_q.almost_empty_n;
	assign almost_full_n_out = s_q.almost_full_n;
	assign serial_mode_out = s_q.serial_mode;
	assign head_buffer_ready_out = buf_ready_q;

	// checks, all on the one system clock
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (reset_in);

	// flag levels against the stored word count
	a_ready_flag_empty: assert property (
		(s_q.count == '0 && !any_rst && !mem_wr)
		|=> output_ready_n_out && !almost_empty_n_out)
		else $error("output ready not raised on empty");
	a_ready_low_band: assert property (
		(s_q.count != '0 && !any_rst && !mem_rd)
		|=> !output_ready_n_out)
		else $error("output ready high while words stored");
	a_half_full_thr: assert property (
		(cnt_next >= HALF_THR && !any_rst)
		|=> !half_full_n_out)
		else $error("half full not low above threshold");
	a_input_ready_full: assert property (
		(cnt_next == CAPACITY && !any_rst)
		|=> input_ready_n_out)
		else $error("input ready not high when full");
	a_output_ready_last: assert property (
		(mem_rd && !mem_wr && s_q.count == CNT_W'(1) && !any_rst)
		|=> output_ready_n_out)
		else $error("output ready not high after last read");

	// partial flags only move on their own clock edges
	a_ae_hold: assert property (
		(!rd_clk_edge_in && !any_rst)
		|=> $stable(almost_empty_n_out))
		else $error("almost empty moved without a read edge");
	a_af_hold: assert property (
		(!wr_clk_edge_in && !any_rst)
		|=> $stable(almost_full_n_out))
		else $error("almost full moved without a write edge");

	// defaults chosen by the load pin at master reset
	a_default_serial: assert property (
		(master_rst && offset_load_select_in)
		|=> s_q.empty_ofs == DEF_OFS_SER && s_q.full_ofs == DEF_OFS_SER)
		else $error("serial defaults wrong");
	a_default_parallel: assert property (
		(master_rst && !offset_load_select_in)
		|=> s_q.empty_ofs == DEF_OFS_PAR && s_q.full_ofs == DEF_OFS_PAR)
		else $error("parallel defaults wrong");
	a_method_kept: assert property (
		!master_rst
		|=> $stable(s_q.serial_mode))
		else $error("loading method changed outside master reset");

	// parallel write order: empty, full, empty
	a_par_write_first: assert property (
		(par_wr && !master_rst && s_q.wr_ptr == PTR_EMPTY)
		|=> s_q.empty_ofs == $past(data_in_bus_in[OFS_W-1:0]) && s_q.wr_ptr == PTR_FULL)
		else $error("first offset write misplaced");
	a_par_write_seq: assert property (
		(par_wr && !master_rst && s_q.wr_ptr == PTR_FULL)
		|=> s_q.full_ofs == $past(data_in_bus_in[OFS_W-1:0]) && s_q.wr_ptr == PTR_EMPTY)
		else $error("second offset write misplaced");
	a_serial_mode_par: assert property (
		(s_q.serial_mode && !ser_shift && !master_rst)
		|=> $stable(s_q.empty_ofs) && $stable(s_q.full_ofs))
		else $error("offsets changed in serial mode without a shift");

	// readback order and zero padding
	a_par_read_out: assert property (
		(par_rd && !any_rst && s_q.rd_ptr == PTR_EMPTY)
		|=> data_out_bus_out[OFS_W-1:0] == $past(s_q.empty_ofs) && s_q.rd_ptr == PTR_FULL)
		else $error("offset readback wrong");
	a_par_read_full: assert property (
		(par_rd && !any_rst && s_q.rd_ptr == PTR_FULL)
		|=> data_out_bus_out[OFS_W-1:0] == $past(s_q.full_ofs) && s_q.rd_ptr == PTR_EMPTY)
		else $error("second offset readback wrong");
	a_readback_pad: assert property (
		(par_rd && !any_rst)
		|=> data_out_bus_out[DATA_W-1:OFS_W] == '0)
		else $error("offset readback upper bits not zero");

	// serial chain stepping
	a_serial_bit: assert property (
		(ser_shift && !master_rst)
		|=> chain[$past(s_q.ser_ptr)] == $past(serial_data_in))
		else $error("serial bit not stored at its position");
	a_serial_wrap: assert property (
		(ser_shift && !master_rst && s_q.ser_ptr == SER_LAST)
		|=> s_q.ser_ptr == '0)
		else $error("serial pointer did not wrap after last bit");
	a_serial_pause: assert property (
		(!ser_shift && !master_rst)
		|=> $stable(s_q.ser_ptr))
		else $error("serial pointer moved while paused");
	a_serial_blocked: assert property (
		(!offset_load_select_in && serial_shift_enable_n_in && !master_rst)
		|=> $stable(s_q.ser_ptr))
		else $error("serial shift while disabled");

	// offset traffic never touches the word count
	a_offset_count: assert property (
		(!offset_load_select_in && !any_rst)
		|=> $stable(s_q.count))
		else $error("offset access moved count");

	// pointer handling by the two resets
	a_mrs_pointers: assert property (
		master_rst
		|=> s_q.wr_ptr == PTR_EMPTY && s_q.rd_ptr == PTR_EMPTY && s_q.ser_ptr == '0)
		else $error("pointers not homed by master reset");
	a_prs_keeps: assert property (
		(partial_rst && !master_rst && !par_wr && !par_rd && !ser_shift)
		|=> $stable(s_q.wr_ptr) && $stable(s_q.rd_ptr) && $stable(s_q.empty_ofs)
		&& $stable(s_q.full_ofs))
		else $error("partial reset disturbed offsets or pointers");

	// main scenarios reached
	c_par_write: cover property (par_wr ##[1:20] par_wr);
	c_serial_done: cover property (ser_shift && s_q.ser_ptr == SER_LAST);
	c_par_read: cover property (par_rd ##[1:20] par_rd);
	c_buffer_full: cover property (!buf_in_ready);
	c_serial_resume: cover property (ser_shift ##1 !ser_shift ##[1:20] ser_shift);
endmodule

// file: verification/ffop_ctrl_model.sv
`timescale 1ns/1ps

// far-side controller: drives reset, offset and memory pins
module ffop_ctrl_model (
	input wire logic clk_in,
	output logic mreset_n_out,
	output logic preset_n_out,
	output logic ofs_load_out,
	output logic wen_n_out,
	output logic ren_n_out,
	output logic shift_en_n_out,
	output logic si_out,
	output logic [ffop_pkg::DATA_W-1:0] d_out,
	output logic wr_edge_out,
	output logic rd_edge_out
);
	import ffop_pkg::*;

	// idle: no operation selected
	initial begin
		{mreset_n_out, preset_n_out, ofs_load_out, wen_n_out, ren_n_out, shift_en_n_out} = 6'h3f;
		{si_out, d_out, wr_edge_out, rd_edge_out} = '0;
	end

	// one access at a time, released bus shows the inverse value
	task automatic op(input logic [3:0] ctl, input logic si, input logic [DATA_W-1:0] d,
		input logic [1:0] edg);
		@(posedge clk_in);
		{ofs_load_out, wen_n_out, ren_n_out, shift_en_n_out} <= ctl;
		si_out <= si;
		d_out <= d;
		{wr_edge_out, rd_edge_out} <= edg;
		@(posedge clk_in);
		{ofs_load_out, wen_n_out, ren_n_out, shift_en_n_out} <= 4'hf;
		si_out <= ~si;
		d_out <= ~d;
		{wr_edge_out, rd_edge_out} <= 2'h0;
	endtask

	// master or partial reset, load pin level chooses the method on master reset only
	task automatic rst(input logic master, input logic ld);
		@(posedge clk_in);
		ofs_load_out <= ld;
		mreset_n_out <= ~master;
		preset_n_out <= master;
		@(posedge clk_in);
		mreset_n_out <= 1'b1;
		preset_n_out <= 1'b1;
		ofs_load_out <= 1'b1;
	endtask

	// complete serial set, paused once with a memory write
	task automatic load_serial(input logic [25:0] bits, input int pause);
		for (int i = 0; i < 26; i++) begin
			if (i == pause) begin
				op(4'h7, 1'b1, '0, 2'h2);
				op(4'hb, 1'b0, 18'h000aa, 2'h2);
			end
			op(4'h6, bits[i], '0, 2'h2);
		end
	endtask
endmodule

// file: verification/tb_top.sv
`timescale 1ns/1ps

module tb_top;
	import ffop_pkg::*;
	logic ref_clk, reset, mreset_n, preset_n, ofs_load, wen_n, ren_n, shift_en_n, si, wr_e, rd_e;
	logic in_rdy_n, or_n, half_n, ae_n, af_n, smode, hb_rdy;
	logic [DATA_W-1:0] din, dout;
	int mismatches = 0;
	int tests_run = 0;
	int cycles = 0;

	ffop_ctrl_model u_ctrl (.clk_in(ref_clk), .mreset_n_out(mreset_n),
		.preset_n_out(preset_n), .ofs_load_out(ofs_load), .wen_n_out(wen_n),
		.ren_n_out(ren_n), .shift_en_n_out(shift_en_n),
		.si_out(si), .d_out(din), .wr_edge_out(wr_e), .rd_edge_out(rd_e));

	ffop_top dut (.ref_clk_in(ref_clk), .reset_in(reset), .master_reset_n_in(mreset_n),
		.partial_reset_n_in(preset_n), .wr_clk_edge_in(wr_e), .rd_clk_edge_in(rd_e),
		.offset_load_select_in(ofs_load), .write_strobe_n_in(wen_n),
		.read_strobe_n_in(ren_n), .serial_shift_enable_n_in(shift_en_n),
		.serial_data_in(si), .data_in_bus_in(din),
		.data_out_bus_out(dout), .input_ready_n_out(in_rdy_n), .output_ready_n_out(or_n),
		.half_full_n_out(half_n), .almost_empty_n_out(ae_n), .almost_full_n_out(af_n),
		.serial_mode_out(smode), .head_buffer_ready_out(hb_rdy));

	// clock and hang guard
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// comparison helpers
	task automatic chk(input string what, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic settle();
		@(posedge ref_clk);
		#1;
	endtask
	// flag order: input ready, output ready, half, almost empty, almost full
	task automatic chkf(input logic [4:0] e);
		settle();
		chk("flags", {13'h0, e}, {13'h0, in_rdy_n, or_n, half_n, ae_n, af_n});
	endtask

	// bus operations
	task automatic pw(input logic [OFS_W-1:0] v);
		u_ctrl.op(4'h3, 1'b0, {{PAD_W{1'b0}}, v}, 2'h2);
	endtask
	task automatic mw(input logic [DATA_W-1:0] v);
		u_ctrl.op(4'hb, 1'b0, v, 2'h2);
	endtask
	task automatic mr(input logic [DATA_W-1:0] e);
		u_ctrl.op(4'hd, 1'b0, '0, 2'h1);
		settle();
		chk("memory word", e, dout);
	endtask
	task automatic rdback(input logic [OFS_W-1:0] e);
		u_ctrl.op(4'h5, 1'b0, '0, 2'h1);
		settle();
		chk("offset readback", {{PAD_W{1'b0}}, e}, dout);
	endtask
	task automatic idle2();
		u_ctrl.op(4'hf, 1'b0, '0, 2'h3);
		u_ctrl.op(4'hf, 1'b0, '0, 2'h3);
	endtask

	// parallel defaults after master reset
	task automatic s_defaults();
		u_ctrl.rst(1'b1, 1'b0);
		chkf(5'h0d);
		chk("method", '0, {17'h0, smode});
		chk("output cleared", '0, dout);
		rdback(13'h007f);
		rdback(13'h007f);
	endtask

	// parallel writes with an interruption, readback order
	task automatic s_parallel();
		pw(13'h0001);
		mw(18'h01234);
		pw(13'h1fff);
		pw(13'h0002);
		chkf(5'h0d & 5'h17);
		rdback(13'h0002);
		mr(18'h01234);
		rdback(13'h1fff);
		rdback(13'h0002);
		chkf(5'h0d);
	endtask

	// partial flags against programmed offsets, fall-through order
	task automatic s_flags();
		for (int i = 0; i < 3; i++) mw(18'h00100 + 18'(i));
		idle2();
		chkf(5'h04);
		mw(18'h00103);
		idle2();
		chkf(5'h06);
		for (int i = 0; i < 4; i++) mr(18'h00100 + 18'(i));
		chkf(5'h0c & 5'h1c | 5'h08);
	endtask

	// serial method: defaults, refused parallel write, paused shift, partial reset
	task automatic s_serial();
		u_ctrl.rst(1'b1, 1'b1);
		settle();
		chk("method", 18'h1, {17'h0, smode});
		rdback(13'h03ff);
		pw(13'h0005);
		rdback(13'h03ff);
		u_ctrl.load_serial({13'h1fff, 13'h0003}, 7);
		rdback(13'h0003);
		u_ctrl.rst(1'b0, 1'b0);
		settle();
		chk("method kept", 18'h1, {17'h0, smode});
		rdback(13'h1fff);
		mw(18'h00201);
		mw(18'h00202);
		idle2();
		chkf(5'h04);
	endtask

	// head buffer fills at eight words and stalls further writes
	task automatic s_buffer();
		for (int i = 0; i < 6; i++) mw(18'h00300 + 18'(i));
		settle();
		chk("head buffer ready", 18'h0, {17'h0, hb_rdy});
		mw(18'h003ff);
		mr(18'h00201);
		mr(18'h00202);
		mr(18'h00300);
		settle();
		chk("head buffer ready", 18'h1, {17'h0, hb_rdy});
	endtask

	// main sequence
	initial begin
		reset = 1'b1;
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		s_defaults();
		s_parallel();
		s_flags();
		s_serial();
		s_buffer();
		end_sim();
	end
endmodule
